// *** include/hsfsb_pkg.sv ***
// Purpose : constants and types of the hot swap fault status byte
// Assumes : one clock, synchronous active-low reset
// Notes   : bit positions of the status byte and the two-wire read engine states
package hsfsb_pkg;
    // -------------------------------------------------------------------
    // status byte field positions
    // -------------------------------------------------------------------
    localparam int unsigned BIT_ADC_OVER  = 0; // adc_overcurrent_flag
    localparam int unsigned BIT_ADC_ALERT = 1; // sticky adc alert
    localparam int unsigned BIT_AN_OFF    = 2; // analog_overcurrent_off
    localparam int unsigned BIT_HS_FAIL   = 3; // hotswap_fail_sticky
    localparam int unsigned BIT_OFF_STAT  = 4; // off status
    localparam int unsigned BIT_OFF_ALERT = 5; // sticky off alert
    localparam logic [1:0]  UNUSED_TOP    = 2'h0;  // bits 7..6
    localparam logic [7:0]  STATUS_RESET  = 8'h00; // status after reset
    // -------------------------------------------------------------------
    // history and serial counts
    // -------------------------------------------------------------------
    localparam int unsigned OC_HISTORY    = 3;     // conversions compared
    localparam logic [3:0]  BITS_PER_BYTE = 4'h8;  // bits per serial byte
    localparam logic [6:0]  ADDR_DEFAULT  = 7'h40; // plain default address
    // -------------------------------------------------------------------
    // read engine states
    // -------------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01, // waiting for start
        ST_ADDR = 5'h02, // shifting address and direction
        ST_AACK = 5'h04, // driving address acknowledge; undriven wait after a master ack
        ST_DATA = 5'h08, // shifting status byte out
        ST_MACK = 5'h10  // master acknowledge slot
    } hsfsb_state_t;
endpackage

// *** hw/hsfsb_top.sv ***
// Purpose : hot swap fault status byte and its two-wire read, byte repeated on master ack
// Assumes : SCL and SDA_IN synchronous to SYS_CLK and much slower than it
// Notes   : alert enables and clear strobe come from the alert enable register
`timescale 1ns/1ps
module hsfsb_top
    import hsfsb_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = hsfsb_pkg::ADDR_DEFAULT, // bus address
    parameter bit         LATCH_OFF = 1'b1                     // 1 latch-off, 0 auto-retry
)(
    input  wire logic       SYS_CLK,      // 125 MHz clock
    input  wire logic       RSTN,         // synchronous reset, active low
    input  wire logic       CONV_DONE,    // pulse: current conversion finished
    input  wire logic       ADC_OVER,     // conversion above alert threshold
    input  wire logic       ADC_TRIP,     // pulse: adc overcurrent alert raised
    input  wire logic       HS_OFF_OC,    // hot swap off by analog overcurrent
    input  wire logic       HS_RETRYING,  // retry in progress or recovered
    input  wire logic       HS_FAIL,      // pulse: hot swap operation failed
    input  wire logic       HOTSWAP_ALERT_ENABLE, // hot swap failure alert enable
    input  wire logic       OFF_ALERT_EN,         // off alert enable
    input  wire logic       ON_PIN,               // external on input, high = on
    input  wire logic       SOFTWARE_OFF_BIT,     // software off bit of control register
    input  wire logic       CLEAR_WR,     // pulse: clear bit written to 1
    input  wire logic       SCL,          // serial clock in
    input  wire logic       SDA_IN,       // serial data in
    output logic            SDA_OUT,      // serial data out, always low
    output logic            SDA_OE,       // high while pulling SDA low
    output logic            CLEAR_BIT,    // clear bit readback
    output logic [7:0]      STATUS_BYTE   // live status byte
);
    // -------------------------------------------------------------------
    // declarations
    // -------------------------------------------------------------------
    logic [OC_HISTORY-1:0] hist_q;          // last conversion compares
    logic                  clear_q;         // self-clearing clear bit
    logic                  adc_alert_q;     // sticky adc alert
    logic                  hotswap_fail_sticky_q; // sticky hot swap failure
    logic                  off_alert_q;     // sticky off alert
    logic                  on_q;            // previous on pin
    logic                  soft_off_q;      // previous software off
    logic [7:0]            status_q;        // registered status byte
    logic                  adc_overcurrent_flag;   // all recent compares over
    logic                  analog_overcurrent_off; // live bit 2
    logic                  off_stat;        // off status
    logic                  off_event;       // off transition seen
    hsfsb_state_t          state_q;         // read engine state
    logic                  scl_q;           // previous scl sample
    logic                  sda_q;           // previous sda sample
    logic [7:0]            shift_q;         // serial shift register
    logic [3:0]            cnt_q;           // bit counter
    logic                  oe_q;            // sda pull-down
    logic                  sda_out_q;       // constant low data
    logic                  scl_rise;        // scl rising
    logic                  scl_fall;        // scl falling
    logic                  start_c;         // start condition
    logic                  stop_c;          // stop condition

    // -------------------------------------------------------------------
    // conversion history: flag needs all recent compares over threshold
    // -------------------------------------------------------------------
    always_ff @(posedge SYS_CLK)
    begin
        if (!RSTN)
            hist_q <= '0;
        else if (CONV_DONE)
            hist_q <= {hist_q[OC_HISTORY-2:0], ADC_OVER};
    end
    assign adc_overcurrent_flag = &hist_q;

    // -------------------------------------------------------------------
    // clear bit: held for one cycle so sticky bits see it, then drops
    // -------------------------------------------------------------------
    always_ff @(posedge SYS_CLK)
    begin
        if (!RSTN)
            clear_q <= 1'b0;
        else
            clear_q <= CLEAR_WR;
    end

    // -------------------------------------------------------------------
    // sticky alerts: a new event wins over a clear in the same cycle
    // -------------------------------------------------------------------
    assign off_event = OFF_ALERT_EN & ((on_q & ~ON_PIN) | (SOFTWARE_OFF_BIT & ~soft_off_q));
    always_ff @(posedge SYS_CLK)
    begin
        if (!RSTN)
        begin
            adc_alert_q           <= 1'b0;
            hotswap_fail_sticky_q <= 1'b0;
            off_alert_q           <= 1'b0;
            on_q                  <= 1'b0;
            soft_off_q            <= 1'b0;
        end
        else
        begin
            adc_alert_q           <= ADC_TRIP | (adc_alert_q & ~clear_q);
            hotswap_fail_sticky_q <= (HS_FAIL & HOTSWAP_ALERT_ENABLE) | (hotswap_fail_sticky_q & ~clear_q);
            off_alert_q           <= off_event | (off_alert_q & ~clear_q);
            on_q                  <= ON_PIN;
            soft_off_q            <= SOFTWARE_OFF_BIT;
        end
    end

    // -------------------------------------------------------------------
    // live bits; retry parts never remember, latch-off parts mirror alert while it is enabled
    // -------------------------------------------------------------------
    always_comb
    begin
        if (LATCH_OFF)
            analog_overcurrent_off = HOTSWAP_ALERT_ENABLE ? hotswap_fail_sticky_q : HS_OFF_OC;
        else
            analog_overcurrent_off = HS_OFF_OC & ~HS_RETRYING;
    end
    assign off_stat = ~ON_PIN | SOFTWARE_OFF_BIT;

    always_ff @(posedge SYS_CLK)
    begin
        if (!RSTN)
            status_q <= STATUS_RESET;
        else
        begin
            status_q                <= {UNUSED_TOP, 6'h00};
            status_q[BIT_ADC_OVER]  <= adc_overcurrent_flag;
            status_q[BIT_ADC_ALERT] <= adc_alert_q;
            status_q[BIT_AN_OFF]    <= analog_overcurrent_off;
            status_q[BIT_HS_FAIL]   <= hotswap_fail_sticky_q;
            status_q[BIT_OFF_STAT]  <= off_stat;
            status_q[BIT_OFF_ALERT] <= off_alert_q;
        end
    end

    // -------------------------------------------------------------------
    // line conditions from sampled pins
    // -------------------------------------------------------------------
    assign scl_rise = SCL & ~scl_q;
    assign scl_fall = ~SCL & scl_q;
    assign start_c  = SCL & scl_q & sda_q & ~SDA_IN;
    assign stop_c   = SCL & scl_q & ~sda_q & SDA_IN;

    always_ff @(posedge SYS_CLK)
    begin
        if (!RSTN)
        begin
            scl_q     <= 1'b1;
            sda_q     <= 1'b1;
            sda_out_q <= 1'b0;
        end
        else
        begin
            scl_q     <= SCL;
            sda_q     <= SDA_IN;
            sda_out_q <= 1'b0;
        end
    end

    // -------------------------------------------------------------------
    // read engine: only reads to our address are acknowledged; a write
    // address is left alone for the command logic elsewhere
    // -------------------------------------------------------------------
    always_ff @(posedge SYS_CLK)
    begin
        if (!RSTN)
        begin
            state_q <= ST_IDLE;
            shift_q <= 8'h00;
            cnt_q   <= 4'h0;
            oe_q    <= 1'b0;
        end
        else if (stop_c)
        begin
            state_q <= ST_IDLE;
            oe_q    <= 1'b0;
        end
        else if (start_c)
        begin
            state_q <= ST_ADDR;
            cnt_q   <= 4'h0;
            oe_q    <= 1'b0;
        end
        else
        begin
            case (state_q)
                ST_ADDR:
                begin
                    if (scl_rise)
                    begin
                        shift_q <= {shift_q[6:0], SDA_IN};
                        cnt_q   <= cnt_q + 4'h1;
                    end
                    else if (scl_fall && cnt_q == BITS_PER_BYTE)
                    begin
                        if (shift_q == {DEV_ADDR, 1'b1})
                        begin
                            state_q <= ST_AACK;
                            oe_q    <= 1'b1;
                        end
                        else
                            state_q <= ST_IDLE;
                    end
                end
                ST_AACK:
                begin
                    // snapshot keeps the byte steady while it shifts out
                    if (scl_fall)
                    begin
                        shift_q <= status_q;
                        oe_q    <= ~status_q[7];
                        cnt_q   <= 4'h0;
                        state_q <= ST_DATA;
                    end
                end
                ST_DATA:
                begin
                    if (scl_rise)
                        cnt_q <= cnt_q + 4'h1;
                    else if (scl_fall)
                    begin
                        if (cnt_q == BITS_PER_BYTE)
                        begin
                            oe_q    <= 1'b0;
                            state_q <= ST_MACK;
                        end
                        else
                        begin
                            shift_q <= {shift_q[6:0], 1'b0};
                            oe_q    <= ~shift_q[6];
                        end
                    end
                end
                ST_MACK:
                begin
                    // a master ack repeats the byte; a nack ends the read
                    if (scl_rise)
                        state_q <= SDA_IN ? ST_IDLE : ST_AACK;
                end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    assign SDA_OUT     = sda_out_q;
    assign SDA_OE      = oe_q;
    assign CLEAR_BIT   = clear_q;
    assign STATUS_BYTE = status_q;

    // -------------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------------
    a_adc_flag_hist: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (CONV_DONE && ADC_OVER && hist_q[1:0] == 2'h3) |=> ##1 status_q[BIT_ADC_OVER])
        else $error("adc flag not raised after three over");
    a_adc_flag_value: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        ##1 status_q[BIT_ADC_OVER] == $past(&hist_q)) else $error("adc flag wrong");
    a_adc_alert_hold: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        ADC_TRIP |=> adc_alert_q ##1 (status_q[BIT_ADC_ALERT] || $past(clear_q)))
        else $error("adc alert not held");
    a_fail_alert_clear: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (hotswap_fail_sticky_q && clear_q && !(HS_FAIL && HOTSWAP_ALERT_ENABLE)) |=> !hotswap_fail_sticky_q)
        else $error("hot swap alert not cleared");
    a_retry_zero: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (!LATCH_OFF && HS_RETRYING) |=> !status_q[BIT_AN_OFF]) else $error("retry shows off");
    a_off_status: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (!ON_PIN || SOFTWARE_OFF_BIT) |=> status_q[BIT_OFF_STAT]) else $error("off status low");
    a_off_alert_set: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (OFF_ALERT_EN && on_q && !ON_PIN) |=> off_alert_q ##1 (off_alert_q || $past(clear_q)))
        else $error("off alert missed");
    a_clear_self: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (clear_q && !CLEAR_WR) |=> !clear_q) else $error("clear bit stuck");
    a_set_wins: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (ADC_TRIP && clear_q) |=> adc_alert_q) else $error("set lost to clear");
    a_top_zero: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        status_q[7:6] == 2'h0) else $error("top bits set");
    a_ack_drive: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (state_q == ST_AACK && $past(state_q) == ST_ADDR) |-> oe_q) else $error("address ack not driven");
    c_read_byte: cover property (@(posedge SYS_CLK) disable iff (!RSTN)
        state_q == ST_DATA ##[1:1000] state_q == ST_MACK);
    c_clear_alert: cover property (@(posedge SYS_CLK) disable iff (!RSTN)
        adc_alert_q && clear_q ##1 !adc_alert_q);
    c_off_alert: cover property (@(posedge SYS_CLK) disable iff (!RSTN) off_event);
    c_byte_repeat: cover property (@(posedge SYS_CLK) disable iff (!RSTN)
        state_q == ST_MACK ##1 state_q == ST_AACK);
endmodule // hsfsb_top

// *** test/hsfsb_host.sv ***
// Purpose : two-wire host that reads the status byte
// Assumes : host lines move 1 ns after a rising clock edge
// Notes   : data wire has a pull-up; phases of 8 clocks keep well above the minimum
`timescale 1ns/1ps
module hsfsb_host
(
    input  wire logic clk,    // system clock
    input  wire logic dut_oe, // device pulls data low
    output logic      scl,    // serial clock to the device
    output logic      sda     // resolved data wire
);
    logic low_q; // host pulls data low
    // either party pulling wins; released wire floats high
    assign sda = !(dut_oe | low_q);
    initial
    begin
        scl   = 1'b1;
        low_q = 1'b0;
    end
    // wait n clocks, then step off the edge
    task automatic w(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // one bit: data moves mid-low so it never changes near a clock edge
    task automatic bit_io(input logic d, output logic q);
        w(4);
        low_q = !d;
        w(4);
        scl = 1'b1;
        q = sda;
        w(8);
        scl = 1'b0;
    endtask
    // start, address with read bit, ack, one byte (two if more), nack, stop
    task automatic read_status(input logic [6:0] addr, input logic more, output logic ack,
                               output logic [7:0] data, output logic [7:0] data2);
        logic [7:0] a;
        logic       q;
        a = {addr, 1'b1};
        data2 = 8'h00;
        low_q = 1'b1; // start: data falls while clock high
        w(8);
        scl = 1'b0;
        for (int i = 7; i >= 0; i--)
            bit_io(a[i], q); // address msb first, read bit last
        bit_io(1'b1, q);
        ack = !q;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, data[i]); // status byte msb first
        if (more)
        begin
            bit_io(1'b0, q); // acknowledge asks for the byte again
            for (int i = 7; i >= 0; i--)
                bit_io(1'b1, data2[i]); // repeated byte
        end
        bit_io(1'b1, q); // no acknowledge ends the read
        w(4);
        low_q = 1'b1;
        w(4);
        scl = 1'b1;
        w(4);
        low_q = 1'b0; // stop
        w(8);
    endtask
endmodule // hsfsb_host

// *** test/test_hot_swap_fault_status_byte.sv ***
// Purpose : self-checking bench for the hot swap fault status byte
// Assumes : one 125 MHz clock; inputs move 1 ns after the rising edge
// Notes   : a retry copy shares all inputs but SCL and SDA_IN; its whole byte is judged, in the analog test only
`timescale 1ns/1ps
module test_hot_swap_fault_status_byte;
    import hsfsb_pkg::*;
    logic       clk, rstn, conv, over, trip, an_off, retry, fail, fail_en, on_pin, soft_off, clr, off_en; // stimulus
    logic       scl, sda, sda_oe, sda_out, clear_bit; // serial lines and clear readback
    logic [7:0] st, st_r;                    // latch-off and retry status
    int         fails, checked;              // verdict counters
    hsfsb_top dut_u (.SYS_CLK(clk), .RSTN(rstn), .CONV_DONE(conv), .ADC_OVER(over), .ADC_TRIP(trip),
        .HS_OFF_OC(an_off), .HS_RETRYING(retry), .HS_FAIL(fail), .HOTSWAP_ALERT_ENABLE(fail_en),
        .OFF_ALERT_EN(off_en), .ON_PIN(on_pin), .SOFTWARE_OFF_BIT(soft_off), .CLEAR_WR(clr), .SCL(scl),
        .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe), .CLEAR_BIT(clear_bit), .STATUS_BYTE(st));
    hsfsb_top #(.LATCH_OFF(1'b0)) dut_rt (.SYS_CLK(clk), .RSTN(rstn), .CONV_DONE(conv), .ADC_OVER(over),
        .ADC_TRIP(trip), .HS_OFF_OC(an_off), .HS_RETRYING(retry), .HS_FAIL(fail), .HOTSWAP_ALERT_ENABLE(fail_en),
        .OFF_ALERT_EN(off_en), .ON_PIN(on_pin), .SOFTWARE_OFF_BIT(soft_off), .CLEAR_WR(clr), .SCL(1'b1),
        .SDA_IN(1'b1), .SDA_OUT(), .SDA_OE(), .CLEAR_BIT(), .STATUS_BYTE(st_r));
    hsfsb_host host_u (.clk(clk), .dut_oe(sda_oe), .scl(scl), .sda(sda));
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // compare; case inequality so an unknown never matches
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one conversion; status shows it two edges later; a low edge keeps pulses apart
    task automatic convert(input logic v);
        over = v;
        conv = 1'b1;
        step(1);
        conv = 1'b0;
        step(1);
    endtask
    task automatic t_adc;
        chk("status after reset", 8'h00, st);
        convert(1'b1);
        convert(1'b1);
        step(2);
        chk("two over", 8'h00, st);
        convert(1'b1);
        step(2);
        chk("three over", 8'h01, st);
        convert(1'b0);
        step(2);
        chk("one under", 8'h00, st);
    endtask
    // each sticky source, then one clear takes all three down
    task automatic t_sticky;
        trip = 1'b1;
        step(1);
        trip = 1'b0;
        step(3);
        chk("adc alert", 8'h02, st);
        fail = 1'b1;
        step(1);
        fail = 1'b0;
        step(3);
        chk("hot swap alert", 8'h0e, st);
        on_pin = 1'b0;
        step(3);
        chk("on pin off", 8'h3e, st);
        on_pin = 1'b1;
        step(3);
        chk("on pin back", 8'h2e, st);
        clr = 1'b1;
        step(1);
        chk("clear bit set", 8'h01, {7'h00, clear_bit});
        clr = 1'b0;
        step(3);
        chk("cleared", 8'h00, st);
        chk("clear bit drops", 8'h00, {7'h00, clear_bit});
    endtask
    // software off, then a trip landing on the clearing edge, then a masked off alert
    task automatic t_soft_off;
        soft_off = 1'b1;
        step(3);
        chk("software off", 8'h30, st);
        soft_off = 1'b0;
        step(3);
        chk("software on", 8'h20, st);
        clr = 1'b1;
        step(1);
        clr = 1'b0;
        trip = 1'b1;
        step(1);
        trip = 1'b0;
        step(3);
        chk("set beats clear", 8'h02, st);
        clr = 1'b1;
        step(1);
        clr = 1'b0;
        step(3);
        off_en = 1'b0;
        soft_off = 1'b1;
        step(3);
        chk("masked off alert", 8'h10, st);
        soft_off = 1'b0;
        off_en = 1'b1;
        step(3);
    endtask
    // alert disabled: bit 2 follows the analog off state, in the retry copy only while not retrying
    task automatic t_analog;
        fail_en = 1'b0;
        an_off = 1'b1;
        step(3);
        chk("latch-off off", 8'h04, st);
        chk("retry off", 8'h04, st_r);
        retry = 1'b1;
        step(3);
        chk("retry in progress", 8'h00, st_r);
        chk("latch-off ignores retry", 8'h04, st);
        an_off = 1'b0;
        retry = 1'b0;
        fail_en = 1'b1;
        step(3);
    endtask
    task automatic t_read;
        logic       ack;
        logic [7:0] data, data2;
        on_pin = 1'b0;
        step(3);
        host_u.read_status(ADDR_DEFAULT, 1'b1, ack, data, data2);
        chk("read ack", 8'h01, {7'h00, ack});
        chk("read byte", 8'h30, data);
        chk("repeated byte", 8'h30, data2);
        chk("data out low", 8'h00, {7'h00, sda_out});
        host_u.read_status(ADDR_DEFAULT ^ 7'h01, 1'b0, ack, data, data2);
        chk("foreign address ack", 8'h00, {7'h00, ack});
    endtask
    task automatic print_verdict;
        if (fails == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        {fails, checked} = '0;
        {rstn, conv, over, trip, an_off, retry, fail, soft_off, clr} = '0;
        {fail_en, on_pin, off_en} = 3'h7;
        step(8);
        rstn = 1'b1;
        t_adc;
        t_sticky;
        t_soft_off;
        t_analog;
        t_read;
        print_verdict;
    end
    // whole run needs about 850 clocks
    initial
    begin
        repeat (6000) @(posedge clk);
        fails++;
        print_verdict;
    end
endmodule // test_hot_swap_fault_status_byte
